// ==== dma_transfer_controller.v ====
// Summary of operation
// - read source word, then write it to destination
// - step both addresses up or down per transfer
// - transfer back to back until counter reaches 0
// - maskable interrupt raised when counter reaches zero
// - transfers use own dedicated address/data bus
// - peripheral registers treated like any memory word
// - option one, cpu always wins contested resource
// - option two, controller always wins contested resource
// - option three, rotate grants, cpu served first
`timescale 1ns/100ps
`default_nettype none
`include "dma_transfer_controller_regs.vh"

module dma_transfer_controller #(
  parameter ADDR_WIDTH  = 24,
  parameter DATA_WIDTH  = 32,
  parameter COUNT_WIDTH = 24
) (
  input  wire                  mclk,
  input  wire                  reset_n,
  // register slave, avalon-mm
  input  wire [4:0]            avs_address,
  input  wire                  avs_read,
  input  wire                  avs_write,
  input  wire [31:0]           avs_writedata,
  input  wire [3:0]            avs_byteenable,
  output reg  [31:0]           avs_readdata,
  output reg                   avs_waitrequest,
  // dedicated transfer bus, avalon-mm master
  output reg  [ADDR_WIDTH-1:0] dma_address,
  output reg                   dma_read,
  output reg                   dma_write,
  output reg  [DATA_WIDTH-1:0] dma_writedata,
  input  wire [DATA_WIDTH-1:0] dma_readdata,
  input  wire                  dma_waitrequest,
  // shared resource arbitration against the cpu
  input  wire                  cpu_req,
  output reg                   cpu_gnt,
  // interrupt to the cpu
  output reg                   irq
);

  // ---------------------------------------------------------------
  // local constants
  // ---------------------------------------------------------------
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_READ  = 2'h1;
  localparam [1:0] S_WRITE = 2'h2;

  localparam [1:0] OWN_NONE = 2'h0;
  localparam [1:0] OWN_CPU  = 2'h1;
  localparam [1:0] OWN_DMA  = 2'h2;

  localparam [ADDR_WIDTH-1:0]  ADDR_ONE  = {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
  localparam [COUNT_WIDTH-1:0] COUNT_ONE = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
  localparam [COUNT_WIDTH-1:0] COUNT_ZERO = {COUNT_WIDTH{1'b0}};

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // byte-lane merge of a bus write into a 32-bit word
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer i;
    begin
      merge_bytes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // address step, up or down by one word
  function [ADDR_WIDTH-1:0] step_addr;
    input [ADDR_WIDTH-1:0] a;
    input                  dec;
    begin
      if (dec) begin
        step_addr = a - ADDR_ONE;
      end else begin
        step_addr = a + ADDR_ONE;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [31:0]            control_reg;
  reg [ADDR_WIDTH-1:0]  source_reg;
  reg [ADDR_WIDTH-1:0]  dest_reg;
  reg [COUNT_WIDTH-1:0] count_reg;
  reg                   done_reg;
  reg [1:0]             mask_reg;
  reg [1:0]             state_reg;
  reg [DATA_WIDTH-1:0]  data_reg;
  reg [1:0]             owner_reg;
  reg                   last_dma_reg;
  reg                   start_pulse_reg;

  wire                  busy      = (state_reg != S_IDLE);
  wire [1:0]            prio_mode = control_reg[`CTL_PRIO_MSB:`CTL_PRIO_LSB];
  wire                  src_dec   = control_reg[`CTL_SRC_DEC_BIT];
  wire                  dst_dec   = control_reg[`CTL_DST_DEC_BIT];
  wire [1:0]            status_w  = {busy, done_reg};

  // ---------------------------------------------------------------
  // register slave decode
  // ---------------------------------------------------------------
  // one wait cycle: readdata is captured on the first edge and the
  // access completes on the second, so readdata comes from a flop
  wire acc_now = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_now  = avs_write & ~avs_waitrequest;
  wire wr_ctl  = wr_now & (avs_address == `REG_CONTROL_OFS);
  wire wr_src  = wr_now & (avs_address == `REG_SOURCE_OFS);
  wire wr_dst  = wr_now & (avs_address == `REG_DEST_OFS);
  wire wr_cnt  = wr_now & (avs_address == `REG_COUNT_OFS);
  wire wr_stat = wr_now & (avs_address == `REG_STATUS_OFS);
  wire wr_mask = wr_now & (avs_address == `REG_MASK_OFS);

  reg [31:0] read_mux;
  reg [31:0] ctl_merged;
  reg [31:0] src_merged;
  reg [31:0] dst_merged;
  reg [31:0] cnt_merged;

  // read multiplexer; unmapped offsets read as zero
  always @* begin
    read_mux = `READ_ZERO;
    case (avs_address)
      `REG_CONTROL_OFS: read_mux = control_reg;
      `REG_SOURCE_OFS:  read_mux[ADDR_WIDTH-1:0] = source_reg;
      `REG_DEST_OFS:    read_mux[ADDR_WIDTH-1:0] = dest_reg;
      `REG_COUNT_OFS:   read_mux[COUNT_WIDTH-1:0] = count_reg;
      `REG_STATUS_OFS:  read_mux[1:0] = status_w;
      `REG_MASK_OFS:    read_mux[1:0] = mask_reg;
      default:          read_mux = `READ_ZERO;
    endcase
  end

  // byte-merged write values for the wide registers
  always @* begin
    src_merged = `READ_ZERO;
    dst_merged = `READ_ZERO;
    cnt_merged = `READ_ZERO;
    src_merged[ADDR_WIDTH-1:0] = source_reg;
    dst_merged[ADDR_WIDTH-1:0] = dest_reg;
    cnt_merged[COUNT_WIDTH-1:0] = count_reg;
    ctl_merged = merge_bytes(control_reg, avs_writedata, avs_byteenable);
    src_merged = merge_bytes(src_merged, avs_writedata, avs_byteenable);
    dst_merged = merge_bytes(dst_merged, avs_writedata, avs_byteenable);
    cnt_merged = merge_bytes(cnt_merged, avs_writedata, avs_byteenable);
  end

  // handshake and readdata capture
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `READ_ZERO;
    end else begin
      if (acc_now) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= read_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // control, mask and status registers
  // ---------------------------------------------------------------
  // start is self-clearing and ignored while a block is running
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg     <= `CONTROL_RESET;
      mask_reg        <= 2'h0;
      start_pulse_reg <= 1'b0;
    end else begin
      start_pulse_reg <= 1'b0;
      if (wr_ctl) begin
        control_reg <= {27'h0, ctl_merged[4:1], 1'b0};
        start_pulse_reg <= ctl_merged[`CTL_START_BIT] & ~busy;
      end
      if (wr_mask & avs_byteenable[0]) begin
        mask_reg <= avs_writedata[1:0];
      end
    end
  end

  // done is sticky, write one clears, a new completion wins
  wire done_set = (state_reg == S_WRITE) & dma_write & ~dma_waitrequest &
                  (count_reg == COUNT_ONE);
  wire zero_set = start_pulse_reg & (count_reg == COUNT_ZERO);
  wire done_clr = wr_stat & avs_byteenable[0] &
                  avs_writedata[`STAT_DONE_BIT];

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (done_reg & ~done_clr) | done_set | zero_set;
    end
  end

  // level interrupt: done gated by its mask bit
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= ((done_reg & ~done_clr) | done_set | zero_set) &
             mask_reg[`STAT_DONE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // shared resource arbiter
  // ---------------------------------------------------------------
  // ownership only changes when the owner has no access open, so a
  // started access is never cut in half by a grant change
  wire dma_want = (state_reg == S_READ) | (state_reg == S_WRITE);
  wire dma_open = dma_read | dma_write;
  reg  [1:0] owner_next;
  // launch only if the resource is kept at this edge too, else a cpu
  // grant and a fresh access would overlap for one cycle
  wire dma_gnt  = (owner_reg == OWN_DMA) & (owner_next == OWN_DMA);

  always @* begin
    owner_next = owner_reg;
    if ((owner_reg == OWN_NONE) ||
        (owner_reg == OWN_CPU && !cpu_req) ||
        (owner_reg == OWN_DMA && !dma_open)) begin
      if (cpu_req && dma_want) begin
        case (prio_mode)
          `PRIO_CPU_FIRST: owner_next = OWN_CPU;
          `PRIO_DMA_FIRST: owner_next = OWN_DMA;
          `PRIO_ROTATE:    owner_next = last_dma_reg ? OWN_CPU
                                                     : OWN_DMA;
          default:         owner_next = OWN_CPU;
        endcase
      end else if (cpu_req) begin
        owner_next = OWN_CPU;
      end else if (dma_want && !(owner_reg == OWN_DMA && !dma_open &&
                                 state_reg == S_IDLE)) begin
        owner_next = OWN_DMA;
      end else begin
        owner_next = OWN_NONE;
      end
    end
  end

  // last_dma starts high, and is set again at each start, so the cpu
  // takes the first contested grant of every rotating block
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      owner_reg    <= OWN_NONE;
      last_dma_reg <= 1'b1;
      cpu_gnt      <= 1'b0;
    end else begin
      owner_reg <= owner_next;
      cpu_gnt   <= (owner_next == OWN_CPU);
      if (owner_next != owner_reg && owner_next != OWN_NONE) begin
        last_dma_reg <= (owner_next == OWN_DMA);
      end else if (start_pulse_reg) begin
        last_dma_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  // address and count registers are locked while busy, so a stray
  // software write cannot tear a running block
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= S_IDLE;
      source_reg    <= {ADDR_WIDTH{1'b0}};
      dest_reg      <= {ADDR_WIDTH{1'b0}};
      count_reg     <= COUNT_ZERO;
      data_reg      <= {DATA_WIDTH{1'b0}};
      dma_address   <= {ADDR_WIDTH{1'b0}};
      dma_read      <= 1'b0;
      dma_write     <= 1'b0;
      dma_writedata <= {DATA_WIDTH{1'b0}};
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (wr_src) begin
            source_reg <= src_merged[ADDR_WIDTH-1:0];
          end
          if (wr_dst) begin
            dest_reg <= dst_merged[ADDR_WIDTH-1:0];
          end
          if (wr_cnt) begin
            count_reg <= cnt_merged[COUNT_WIDTH-1:0];
          end
          if (start_pulse_reg && count_reg != COUNT_ZERO) begin
            state_reg <= S_READ;
          end
        end
        S_READ: begin
          // any address is legal, peripherals included
          if (dma_read && !dma_waitrequest) begin
            dma_read  <= 1'b0;
            data_reg  <= dma_readdata;
            state_reg <= S_WRITE;
          end else if (!dma_read && dma_gnt) begin
            dma_address <= source_reg;
            dma_read    <= 1'b1;
          end
        end
        S_WRITE: begin
          if (dma_write && !dma_waitrequest) begin
            dma_write  <= 1'b0;
            source_reg <= step_addr(source_reg, src_dec);
            dest_reg   <= step_addr(dest_reg, dst_dec);
            count_reg  <= count_reg - COUNT_ONE;
            if (count_reg == COUNT_ONE) begin
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_READ;
            end
          end else if (!dma_write && dma_gnt) begin
            dma_address   <= dest_reg;
            dma_writedata <= data_reg;
            dma_write     <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          dma_read  <= 1'b0;
          dma_write <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== dma_transfer_controller_regs.vh ====
`ifndef DMA_TRANSFER_CONTROLLER_REGS_VH
`define DMA_TRANSFER_CONTROLLER_REGS_VH

// ---------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ---------------------------------------------------------------
`define REG_CONTROL_OFS   5'h00
`define REG_SOURCE_OFS    5'h04
`define REG_DEST_OFS      5'h08
`define REG_COUNT_OFS     5'h0C
`define REG_STATUS_OFS    5'h10
`define REG_MASK_OFS      5'h14

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTL_START_BIT     0
`define CTL_SRC_DEC_BIT   1
`define CTL_DST_DEC_BIT   2
`define CTL_PRIO_LSB      3
`define CTL_PRIO_MSB      4

// ---------------------------------------------------------------
// status and mask fields (same layout)
// ---------------------------------------------------------------
`define STAT_DONE_BIT     0
`define STAT_BUSY_BIT     1

// ---------------------------------------------------------------
// priority option encodings
// ---------------------------------------------------------------
`define PRIO_CPU_FIRST    2'h0
`define PRIO_DMA_FIRST    2'h1
`define PRIO_ROTATE       2'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CONTROL_RESET     32'h00000000
`define MASK_RESET        32'h00000000
`define READ_ZERO         32'h00000000

`endif

// ==== word_memory_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module word_memory_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [23:0] dma_address,
  input  wire logic        dma_read,
  input  wire logic        dma_write,
  input  wire logic [31:0] dma_writedata,
  input  wire logic [1:0]  stall,
  output var  logic [31:0] dma_readdata,
  output var  logic        dma_waitrequest
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  // ram and peripheral words share one flat array, no special cases
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h5A000000 ^ (i * 32'h10101);
  // answer after a random stall; an idle data bus keeps toggling so a
  // stale word is never mistaken for a fresh one
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dma_waitrequest <= 1'b1;
      dma_readdata <= 32'h0;
      wait_cnt <= 2'h0;
    end else if (!dma_waitrequest) begin
      dma_waitrequest <= 1'b1;
      dma_readdata <= ~dma_readdata;
      wait_cnt <= 2'h0;
      if (dma_write) mem[dma_address[7:0]] <= dma_writedata;
    end else if ((dma_read || dma_write) && wait_cnt >= stall) begin
      dma_waitrequest <= 1'b0;
      if (dma_read) dma_readdata <= mem[dma_address[7:0]];
    end else if (dma_read || dma_write) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      dma_readdata <= ~dma_readdata;
    end
  end
endmodule
`default_nettype wire

// ==== dma_transfer_controller_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dma_transfer_controller_regs.vh"
module dma_checker #(
  parameter ADDR_WIDTH = 24,
  parameter DATA_WIDTH = 32
) (
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic [4:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [ADDR_WIDTH-1:0] dma_address,
  input wire logic                  dma_read,
  input wire logic                  dma_write,
  input wire logic [DATA_WIDTH-1:0] dma_writedata,
  input wire logic [DATA_WIDTH-1:0] dma_readdata,
  input wire logic                  dma_waitrequest,
  input wire logic                  cpu_gnt,
  input wire logic                  irq
);
  logic [ADDR_WIDTH-1:0] src_exp;
  logic [ADDR_WIDTH-1:0] dst_exp;
  logic [DATA_WIDTH-1:0] rd_word;
  logic [2:1]            dir;
  logic                  mask_on;
  wire                   wr_acc = avs_write && !avs_waitrequest;
  // shadow software's programming so expected addresses follow it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir <= 2'h0;
      mask_on <= 1'b0;
      src_exp <= '0;
      dst_exp <= '0;
      rd_word <= '0;
    end else begin
      if (wr_acc && avs_address == `REG_CONTROL_OFS) dir <= avs_writedata[2:1];
      if (wr_acc && avs_address == `REG_MASK_OFS) mask_on <= avs_writedata[0];
      if (wr_acc && avs_address == `REG_SOURCE_OFS)
        src_exp <= avs_writedata[ADDR_WIDTH-1:0];
      if (wr_acc && avs_address == `REG_DEST_OFS)
        dst_exp <= avs_writedata[ADDR_WIDTH-1:0];
      if (dma_read && !dma_waitrequest) begin
        rd_word <= dma_readdata;
        src_exp <= dir[1] ? src_exp - 1'b1 : src_exp + 1'b1;
      end
      if (dma_write && !dma_waitrequest)
        dst_exp <= dir[2] ? dst_exp - 1'b1 : dst_exp + 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence rd_acc;
    dma_read && !dma_waitrequest;
  endsequence
  sequence wr_go;
    $rose(dma_write);
  endsequence
  reg_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("register access not answered");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("register answer longer than one cycle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address > `REG_MASK_OFS |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  hold_request_a: assert property (
    (dma_read || dma_write) && dma_waitrequest |=>
    $stable({dma_read, dma_write, dma_address, dma_writedata}))
    else $error("transfer request dropped or changed");
  one_dir_a: assert property (!(dma_read && dma_write))
    else $error("read and write together");
  read_then_write_a: assert property (rd_acc |-> ##[2:40] dma_write)
    else $error("read not followed by write");
  copy_word_a: assert property (wr_go |-> dma_writedata == rd_word)
    else $error("written word differs from read word");
  src_step_a: assert property ($rose(dma_read) |-> dma_address == src_exp)
    else $error("source address wrong");
  dst_step_a: assert property (wr_go |-> dma_address == dst_exp)
    else $error("destination address wrong");
  irq_mask_a: assert property (irq |-> mask_on || $past(mask_on))
    else $error("interrupt while masked");
  gnt_excl_a: assert property (cpu_gnt |-> !dma_read && !dma_write)
    else $error("transfer while cpu owns resource");
endmodule
bind dma_transfer_controller dma_checker #(
  .ADDR_WIDTH (ADDR_WIDTH),
  .DATA_WIDTH (DATA_WIDTH)
) checker_i (
  .mclk            (mclk),
  .reset_n         (reset_n),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .dma_address     (dma_address),
  .dma_read        (dma_read),
  .dma_write       (dma_write),
  .dma_writedata   (dma_writedata),
  .dma_readdata    (dma_readdata),
  .dma_waitrequest (dma_waitrequest),
  .cpu_gnt         (cpu_gnt),
  .irq             (irq)
);
`default_nettype wire

// ==== dma_transfer_controller_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dma_transfer_controller_regs.vh"
module dma_transfer_controller_test;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [23:0] dma_address;
  logic        dma_read;
  logic        dma_write;
  logic [31:0] dma_writedata;
  logic [31:0] dma_readdata;
  logic        dma_waitrequest;
  logic        cpu_req = 1'b0;
  logic        cpu_gnt;
  logic        irq;
  logic [1:0]  stall = 2'h0;
  logic [31:0] seed = 32'hF1DD4DB8;
  logic [56:0] dq[$];
  logic [31:0] rq[$];
  int          fail_count = 0;
  int          checks = 0;
  int          accs = 0;
  dma_transfer_controller dut (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_address(dma_address), .dma_read(dma_read), .dma_write(dma_write),
    .dma_writedata(dma_writedata), .dma_readdata(dma_readdata),
    .dma_waitrequest(dma_waitrequest), .cpu_req(cpu_req),
    .cpu_gnt(cpu_gnt), .irq(irq));
  word_memory_model mem_i (.mclk(mclk), .reset_n(reset_n),
    .dma_address(dma_address), .dma_read(dma_read), .dma_write(dma_write),
    .dma_writedata(dma_writedata), .stall(stall),
    .dma_readdata(dma_readdata), .dma_waitrequest(dma_waitrequest));
  always #10 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pat(input logic [7:0] a);
    pat = 32'h5A000000 ^ ({24'h0, a} * 32'h10101);
  endfunction
  // random stall so the memory answers both promptly and slowly
  always @(posedge mclk) begin
    seed <= lfsr(seed);
    stall <= seed[1:0];
  end
  // compare each accepted transfer and read answer with the oldest note
  always @(posedge mclk) begin
    if ((dma_read || dma_write) && dma_waitrequest === 1'b0) begin
      accs <= accs + 1;
      checks++;
      if (dq.size() == 0 || dq[0] !== {dma_write, dma_address,
          dma_write ? dma_writedata : dma_readdata}) begin
        fail_count++;
        $display("Error %0t: transfer at %h", $time, dma_address);
      end
      if (dq.size() != 0) void'(dq.pop_front());
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      checks++;
      if (rq.size() == 0 || rq[0] !== avs_readdata) begin
        fail_count++;
        $display("Error %0t: read %h", $time, avs_readdata);
      end
      if (rq.size() != 0) void'(rq.pop_front());
    end
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) begin
      fail_count++;
      $display("Error %0t: register bus hang", $time);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic xfer(input logic [7:0] s, input logic [7:0] d,
                      input logic [23:0] c, input logic [4:0] ctl);
    bus(1'b1, `REG_SOURCE_OFS, {24'h0, s});
    bus(1'b1, `REG_DEST_OFS, {24'h0, d});
    bus(1'b1, `REG_COUNT_OFS, {8'h0, c});
    for (int i = 0; i < c; i++) begin
      dq.push_back({1'b0, 16'h0, s, pat(s)});
      dq.push_back({1'b1, 16'h0, d, pat(s)});
      s = ctl[1] ? s - 8'h1 : s + 8'h1;
      d = ctl[2] ? d - 8'h1 : d + 8'h1;
    end
    bus(1'b1, `REG_CONTROL_OFS, {27'h0, ctl[4:1], 1'b1});
  endtask
  // drain the notes, check the done flag, then unmask to raise irq and clear it
  task automatic settle(input logic e);
    int n;
    n = 0;
    while ((dq.size() != 0 || irq !== e) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    checks++;
    if (n == 400 || irq !== e) begin
      fail_count++;
      $display("Error %0t: block end or irq wrong", $time);
    end
    rd(`REG_STATUS_OFS, 32'h1);
    bus(1'b1, `REG_MASK_OFS, 32'h1);
    repeat (2) @(posedge mclk);
    checks++;
    if (irq !== 1'b1) $display("Error %0t: irq not raised", $time);
    if (irq !== 1'b1) fail_count++;
    bus(1'b1, `REG_STATUS_OFS, 32'h1);
    rd(`REG_STATUS_OFS, 32'h0);
    checks++;
    if (irq !== 1'b0) $display("Error %0t: irq not cleared", $time);
    if (irq !== 1'b0) fail_count++;
    $display("test block done at %0t", $time);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    $display("Error %0t: watchdog", $time);
    complete_run;
  end
  initial begin
    int n;
    int a0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`REG_CONTROL_OFS, `CONTROL_RESET);
    rd(`REG_MASK_OFS, `MASK_RESET);
    rd(`REG_STATUS_OFS, `READ_ZERO);
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    rd(5'h18, `READ_ZERO);
    $display("test registers done");
    bus(1'b1, `REG_MASK_OFS, 32'h1);
    xfer(8'h10, 8'h40, 24'h3, 5'h00);
    settle(1'b1);
    bus(1'b1, `REG_MASK_OFS, 32'h0);
    xfer(8'h2F, 8'h7F, 24'h2, 5'h06);
    settle(1'b0);
    bus(1'b1, `REG_MASK_OFS, 32'h0);
    xfer(8'h80, 8'h90, 24'h0, 5'h00);
    settle(1'b0);
    for (int p = 0; p < 3; p++) begin
      a0 = accs;
      xfer(8'hA0 + 8'(p * 8), 8'hC0 + 8'(p * 8), 24'h4, {p[1:0], 3'h4});
      // raise the cpu request as the engine leaves idle, so both contend
      @(posedge mclk);
      cpu_req <= 1'b1;
      n = 0;
      while (cpu_gnt !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
      end
      checks++;
      if (n == 200 || (p == 1) != (accs != a0)) begin
        fail_count++;
        $display("Error %0t: grant order in option %0d", $time, p);
      end
      repeat (3) @(posedge mclk);
      cpu_req <= 1'b0;
      settle(1'b1);
    end
    complete_run;
  end
endmodule
`default_nettype wire
